// ===== hw/ncss_core_state.v
`timescale 1ns/10ps
`include "ncss_map.vh"
// Functional notes
// - Data pointer is Z, X, Y: ten bits
// - Fourteen-bit PC: seven-bit page, seven-bit offset
// - Eight-entry 14-bit return stack, 3-bit pointer
// - Timer reloads eight bits; LCD reload four
// - Skip fetches next instruction but suppresses it
// - Skip advances PC by one, never two
// - Skipped slot keeps its normal cycle count
// - Skipped table call or returns take one cycle
module ncss_core_state (
   input wire clk_in, // 200 MHz core clock
   input wire rst_n_in, // Synchronous reset, active low
   input wire instr_valid_in, // Decoded instruction present
   input wire [`NCSS_OP_W-1:0] op_in, // Micro operation
   input wire [1:0] cycles_in, // Machine cycles when executed, 1..3
   input wire skip_cond_in, // Skip condition of a skipping op
   input wire [`NCSS_PC_W-1:0] operand_in, // Immediate or target
   output reg [`NCSS_PC_W-1:0] pc_out, // Program counter
   output reg [`NCSS_PTR_W-1:0] ram_pointer_out, // RAM operand address
   output reg [`NCSS_ACC_W-1:0] acc_out, // Accumulator
   output reg [`NCSS_ACC_W-1:0] reg_b_out, // Second working register
   output reg [`NCSS_HBITS_W-1:0] table_high_bits_reg_out, // Table high bits
   output reg [`NCSS_PAIR_W-1:0] pair_out, // Register pair holder
   output reg [`NCSS_SP_W-1:0] sp_out, // Stack pointer
   output reg [`NCSS_RLD_W-1:0] prescaler_reload_reg_out, // Prescaler reload
   output reg [`NCSS_RLD_W-1:0] timer_one_reload_reg_out, // Timer 1 reload
   output reg [`NCSS_RLD_W-1:0] timer_three_reload_reg_out, // Timer 3 reload
   output reg [`NCSS_RLD_W-1:0] timer_two_reload_low_out, // Timer 2 reload low
   output reg [`NCSS_RLD_W-1:0] timer_two_reload_high_out, // Timer 2 reload high
   output reg [`NCSS_LCD_RLD_W-1:0] lcd_timer_reload_reg_out, // LCD timer reload
   output reg busy_out, // Multi-cycle slot in progress
   output reg suppress_out // Current slot is suppressed
);
   // =====================================================
   // State
   // =====================================================
   reg [`NCSS_ACC_W-1:0] reg_x_q;
   reg [`NCSS_ACC_W-1:0] reg_y_q;
   reg [1:0] reg_z_q;
   reg [`NCSS_PC_W-1:0] pc_q;
   reg [`NCSS_SP_W-1:0] sp_q;
   reg skip_pend_q;
   reg [1:0] wait_q;
   reg ret_pend_q;
   wire [`NCSS_PAGE_W-1:0] pc_page_part;
   wire [`NCSS_PAGE_W-1:0] pc_offset_part;
   wire [`NCSS_PC_W-1:0] pc_inc;
   wire [`NCSS_PC_W-1:0] stk_rd;
   wire take;
   wire is_ctl;
   wire execute;
   wire [`NCSS_SP_W-1:0] sp_inc;
   wire [`NCSS_SP_W-1:0] sp_dec;
   assign pc_page_part = pc_q[`NCSS_PC_W-1:`NCSS_PAGE_W];
   assign pc_offset_part = pc_q[`NCSS_PAGE_W-1:0];
   // Page wraps within itself; sequential fetch never crosses pages
   assign pc_inc = {pc_page_part, pc_offset_part + 7'h01};
   assign take = instr_valid_in && (wait_q == 2'h0) && !ret_pend_q;
   assign is_ctl = (op_in == `NCSS_OP_TABCALL) || (op_in == `NCSS_OP_RET) ||
      (op_in == `NCSS_OP_RETSKIP);
   assign execute = take && !skip_pend_q;
   assign sp_inc = sp_q + 3'h1;
   assign sp_dec = sp_q - 3'h1;
   // =====================================================
   // Decode
   // =====================================================
   wire op_push;
   wire stk_wr_en;
   wire [2:0] rld_sel;
   wire [`NCSS_RLD_W-1:0] rld_data;
   wire [`NCSS_PTR_W-1:0] ram_pointer;
   assign op_push = (op_in == `NCSS_OP_CALL) || (op_in == `NCSS_OP_TABCALL);
   // A push only on an executed slot; a skipped call leaves the stack alone
   assign stk_wr_en = execute && op_push;
   assign rld_sel = operand_in[10:8];
   assign rld_data = operand_in[7:0];
   assign ram_pointer[`NCSS_PTR_X_LSB-1:`NCSS_PTR_Y_LSB] = reg_y_q;
   assign ram_pointer[`NCSS_PTR_Z_LSB-1:`NCSS_PTR_X_LSB] = reg_x_q;
   assign ram_pointer[`NCSS_PTR_W-1:`NCSS_PTR_Z_LSB] = reg_z_q;
   // =====================================================
   // Return stack
   // =====================================================
   // Read slot is the current top so a return sees it one cycle later
   // Nine pushes without a pop reuse slot zero; there is no overflow
   // flag, so deep nesting is the program's own concern
   ncss_stack_mem u_stack (
      .clk_in(clk_in),
      .wr_en_in(stk_wr_en),
      .wr_addr_in(sp_inc),
      .wr_data_in(pc_inc),
      .rd_addr_in(sp_q),
      .rd_data_out(stk_rd)
   );
   // =====================================================
   // Sequencing
   // =====================================================
   // One slot is taken per free edge. A return holds the core one more
   // edge, as the stack read is registered; the pointer steps back then.
   // A pending skip is spent on the next taken slot, whatever it is, and
   // a skipped table call or return gives back its extra cycles at once.
   // Trade-off: the decoder must hold its offer while busy_out is high.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pc_q <= `NCSS_PC_RST;
         sp_q <= `NCSS_SP_RST;
         skip_pend_q <= 1'b0;
         wait_q <= 2'h0;
         ret_pend_q <= 1'b0;
         busy_out <= 1'b0;
         suppress_out <= 1'b0;
      end else begin
         suppress_out <= 1'b0;
         if (ret_pend_q) begin
            // Second cycle of a return: stack data now registered
            pc_q <= stk_rd;
            sp_q <= sp_dec;
            ret_pend_q <= 1'b0;
            busy_out <= 1'b0;
         end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
            busy_out <= (wait_q != 2'h1);
         end else if (take && skip_pend_q) begin
            pc_q <= pc_inc;
            skip_pend_q <= 1'b0;
            suppress_out <= 1'b1;
            if (is_ctl || (cycles_in <= 2'h1)) begin
               wait_q <= 2'h0;
               busy_out <= 1'b0;
            end else begin
               wait_q <= cycles_in - 2'h1;
               busy_out <= 1'b1;
            end
         end else if (execute) begin
            wait_q <= (cycles_in > 2'h1) ? cycles_in - 2'h1 : 2'h0;
            busy_out <= (cycles_in > 2'h1);
            pc_q <= pc_inc;
            case (op_in)
               `NCSS_OP_CALL, `NCSS_OP_TABCALL: begin
                  sp_q <= sp_inc;
                  pc_q <= operand_in;
               end
               `NCSS_OP_JUMP: pc_q <= operand_in;
               `NCSS_OP_RET: begin
                  ret_pend_q <= 1'b1;
                  wait_q <= 2'h0;
                  busy_out <= 1'b1;
               end
               `NCSS_OP_RETSKIP: begin
                  ret_pend_q <= 1'b1;
                  skip_pend_q <= 1'b1;
                  wait_q <= 2'h0;
                  busy_out <= 1'b1;
               end
               `NCSS_OP_SKIP: skip_pend_q <= skip_cond_in;
               default: ;
            endcase
         end
      end
   end
   // =====================================================
   // Architectural registers
   // =====================================================
   // Written only by an executed slot, so a suppressed one changes none
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         reg_x_q <= 4'h0;
         reg_y_q <= 4'h0;
         reg_z_q <= 2'h0;
         acc_out <= 4'h0;
         reg_b_out <= 4'h0;
         table_high_bits_reg_out <= 3'h0;
         pair_out <= 8'h00;
         prescaler_reload_reg_out <= 8'h00;
         timer_one_reload_reg_out <= 8'h00;
         timer_three_reload_reg_out <= 8'h00;
         timer_two_reload_low_out <= 8'h00;
         timer_two_reload_high_out <= 8'h00;
         lcd_timer_reload_reg_out <= 4'h0;
      end else if (execute) begin
         case (op_in)
            `NCSS_OP_LD_A: acc_out <= operand_in[3:0];
            `NCSS_OP_LD_B: reg_b_out <= operand_in[3:0];
            `NCSS_OP_LD_XY: begin
               reg_x_q <= operand_in[7:4];
               reg_y_q <= operand_in[3:0];
            end
            `NCSS_OP_LD_Z: reg_z_q <= operand_in[1:0];
            `NCSS_OP_LD_HBITS: table_high_bits_reg_out <= operand_in[2:0];
            `NCSS_OP_LD_PAIR: pair_out <= operand_in[7:0];
            `NCSS_OP_LD_RLD: begin
               case (rld_sel)
                  `NCSS_RLD_PS: prescaler_reload_reg_out <= rld_data;
                  `NCSS_RLD_T1: timer_one_reload_reg_out <= rld_data;
                  `NCSS_RLD_T3: timer_three_reload_reg_out <= rld_data;
                  `NCSS_RLD_T2L: timer_two_reload_low_out <= rld_data;
                  `NCSS_RLD_T2H: timer_two_reload_high_out <= rld_data;
                  `NCSS_RLD_LCD: lcd_timer_reload_reg_out <= rld_data[3:0];
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end
   // =====================================================
   // Output copies
   // =====================================================
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pc_out <= `NCSS_PC_RST;
         sp_out <= `NCSS_SP_RST;
         ram_pointer_out <= 10'h000;
      end else begin
         // Copies lag state by one cycle so every output is a flop
         pc_out <= pc_q;
         sp_out <= sp_q;
         ram_pointer_out <= ram_pointer;
      end
   end
endmodule

// ===== hw/ncss_map.vh
`ifndef NCSS_MAP_VH
`define NCSS_MAP_VH
// Widths of architectural state
`define NCSS_ACC_W 4
`define NCSS_HBITS_W 3
`define NCSS_PAIR_W 8
`define NCSS_PTR_W 10
`define NCSS_PC_W 14
`define NCSS_PAGE_W 7
`define NCSS_SP_W 3
`define NCSS_STK_DEPTH 8
`define NCSS_RLD_W 8
`define NCSS_LCD_RLD_W 4
// Field positions in the data pointer {z, x, y}
`define NCSS_PTR_Y_LSB 0
`define NCSS_PTR_X_LSB 4
`define NCSS_PTR_Z_LSB 8
// Micro operation codes on op_in
`define NCSS_OP_W 4
`define NCSS_OP_NOP 4'h0
`define NCSS_OP_LD_A 4'h1
`define NCSS_OP_LD_B 4'h2
`define NCSS_OP_LD_XY 4'h3
`define NCSS_OP_LD_Z 4'h4
`define NCSS_OP_LD_HBITS 4'h5
`define NCSS_OP_LD_PAIR 4'h6
`define NCSS_OP_LD_RLD 4'h7
`define NCSS_OP_CALL 4'h8
`define NCSS_OP_RET 4'h9
`define NCSS_OP_JUMP 4'hA
`define NCSS_OP_TABCALL 4'hB
`define NCSS_OP_RETSKIP 4'hC
`define NCSS_OP_SKIP 4'hD
// Reload register select for LD_RLD
`define NCSS_RLD_PS 3'h0
`define NCSS_RLD_T1 3'h1
`define NCSS_RLD_T3 3'h2
`define NCSS_RLD_T2L 3'h3
`define NCSS_RLD_T2H 3'h4
`define NCSS_RLD_LCD 3'h5
// Reset values
`define NCSS_PC_RST 14'h0000
`define NCSS_SP_RST 3'h7
`endif

// ===== hw/ncss_stack_mem.v
`timescale 1ns/10ps
`include "ncss_map.vh"
module ncss_stack_mem (
   input wire clk_in, // Core clock
   input wire wr_en_in, // Write strobe
   input wire [`NCSS_SP_W-1:0] wr_addr_in, // Write slot
   input wire [`NCSS_PC_W-1:0] wr_data_in, // Saved PC
   input wire [`NCSS_SP_W-1:0] rd_addr_in, // Read slot
   output reg [`NCSS_PC_W-1:0] rd_data_out // Registered read
);
   reg [`NCSS_PC_W-1:0] mem [0:`NCSS_STK_DEPTH-1];
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// ===== dv/ncss_core_state_chk.sv
`timescale 1ns/10ps
`include "ncss_map.vh"
module ncss_core_state_chk (
   input wire clk_in, // Core clock
   input wire rst_n_in, // Sync reset
   input wire instr_valid_in, // Offer
   input wire [3:0] op_in, // Micro op
   input wire [1:0] cycles_in, // Cycle count
   input wire skip_cond_in, // Skip condition
   input wire [13:0] operand_in, // Operand
   input wire [13:0] pc_out, // PC
   input wire [9:0] ram_pointer_out, // RAM pointer
   input wire [3:0] acc_out, // Accumulator
   input wire [3:0] reg_b_out, // Register B
   input wire [2:0] sp_out, // Stack pointer
   input wire busy_out, // Busy
   input wire suppress_out // Suppressed slot
);
   // ==========
   // Skip tracking; a suppressed skip must not arm another one
   reg pend_q;
   wire take = instr_valid_in && !busy_out;
   wire spec = op_in == `NCSS_OP_TABCALL || op_in == `NCSS_OP_RET || op_in == `NCSS_OP_RETSKIP;
   always @(posedge clk_in) begin
      if (!rst_n_in) pend_q <= 1'b0;
      else if (take) pend_q <= !pend_q && (op_in == `NCSS_OP_RETSKIP ||
         (op_in == `NCSS_OP_SKIP && skip_cond_in));
   end
   // ==========
   // Properties
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence busy_two;
      busy_out ##1 busy_out ##1 !busy_out;
   endsequence
   rst_vals_a: assert property ($rose(rst_n_in) |-> sp_out == 3'h7 && pc_out == 14'h0000)
      else $error("reset values wrong");
   skip_once_a: assert property (suppress_out |=> !suppress_out)
      else $error("suppress longer than one cycle");
   skip_keep_a: assert property (suppress_out |-> $stable(acc_out) && $stable(reg_b_out))
      else $error("suppressed slot changed a register");
   skip_ptr_a: assert property (suppress_out |=> $stable(sp_out) && $stable(ram_pointer_out))
      else $error("suppressed slot changed a pointer");
   skip_step_a: assert property (suppress_out |=>
      pc_out == {$past(pc_out[13:7]), $past(pc_out[6:0]) + 7'h01})
      else $error("pc step on skip wrong");
   skip_short_a: assert property (suppress_out && $past(spec) |-> !busy_out)
      else $error("skipped call or return not one cycle");
   skip_time_a: assert property (suppress_out && !$past(spec) && $past(cycles_in) == 2'h3 |-> busy_two)
      else $error("skipped slot cycle count wrong");
   load_acc_a: assert property (take && !pend_q && op_in == `NCSS_OP_LD_A |=>
      acc_out == $past(operand_in[3:0])) else $error("accumulator load wrong");
   load_z_a: assert property (take && !pend_q && op_in == `NCSS_OP_LD_Z |=> ##1
      ram_pointer_out[9:8] == $past(operand_in[1:0], 2)) else $error("pointer load wrong");
endmodule
bind ncss_core_state ncss_core_state_chk u_chk (.clk_in, .rst_n_in, .instr_valid_in, .op_in,
   .cycles_in, .skip_cond_in, .operand_in, .pc_out, .ram_pointer_out, .acc_out, .reg_b_out,
   .sp_out, .busy_out, .suppress_out);

// ===== dv/ncss_core_state_tb.sv
`timescale 1ns/10ps
`include "ncss_map.vh"
module ncss_core_state_tb;
   reg clk_in, rst_n_in, instr_valid_in, skip_cond_in;
   reg [3:0] op_in;
   reg [1:0] cycles_in;
   reg [13:0] operand_in, pc_m, ret_m;
   reg [7:0] r_m;
   reg [3:0] a_m;
   wire [13:0] pc_out;
   wire [9:0] rp;
   wire [3:0] acc, rb, lcd;
   wire [2:0] hb, sp;
   wire [7:0] pair, ps, t1, t3, t2l, t2h;
   wire busy, supp;
   wire [47:0] rlds = {4'h0, lcd, t2h, t2l, t3, t1, ps};
   wire [15:0] skp_ops = {`NCSS_OP_LD_A, `NCSS_OP_TABCALL, `NCSS_OP_RET, `NCSS_OP_RETSKIP};
   reg [1:0] z_m;
   integer n_fail, n_checks, nb, ns, i;
   ncss_core_state dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
      .op_in(op_in), .cycles_in(cycles_in), .skip_cond_in(skip_cond_in), .operand_in(operand_in),
      .pc_out(pc_out), .ram_pointer_out(rp), .acc_out(acc), .reg_b_out(rb),
      .table_high_bits_reg_out(hb), .pair_out(pair), .sp_out(sp), .prescaler_reload_reg_out(ps),
      .timer_one_reload_reg_out(t1), .timer_three_reload_reg_out(t3),
      .timer_two_reload_low_out(t2l), .timer_two_reload_high_out(t2h),
      .lcd_timer_reload_reg_out(lcd), .busy_out(busy), .suppress_out(supp));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task test_done;
      begin
         if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [8*5:1] nm, input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   function [13:0] nxt(input [13:0] p);
      nxt = {p[13:7], p[6:0] + 7'h01};
   endfunction
   // ==========
   // One instruction, then count busy cycles and let outputs settle
   task issue(input [3:0] op, input [1:0] cy, input sk, input [13:0] d);
      begin
         instr_valid_in = 1'b1; op_in = op; cycles_in = cy; skip_cond_in = sk; operand_in = d;
         pc_m = nxt(pc_m);
         @(posedge clk_in);
         #1 instr_valid_in = 1'b0;
         nb = 0;
         ns = 0;
         repeat (4) begin
            @(negedge clk_in);
            if (busy === 1'b1) nb = nb + 1;
            if (supp === 1'b1) ns = ns + 1;
         end
         @(posedge clk_in);
         #1;
      end
   endtask
   initial begin
      n_fail = 0; n_checks = 0; pc_m = 14'h0000;
      z_m = 2'h0;
      rst_n_in = 1'b0; instr_valid_in = 1'b0; op_in = 4'h0; cycles_in = 2'h1;
      skip_cond_in = 1'b0; operand_in = 14'h0000;
      void'($urandom(51075));
      repeat (3) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      chk("sp", sp, 3'h7);
      chk("pc", pc_out, 14'h0000);
      for (i = 0; i < 24; i = i + 1) begin
         r_m = 8'($urandom);
         issue(4'(`NCSS_OP_LD_A + i % 4), 2'h1, 1'b0, {6'h00, r_m});
         case (i % 4)
            0: chk("acc", acc, r_m[3:0]);
            1: chk("regb", rb, r_m[3:0]);
            2: chk("ptr", rp, {z_m, r_m});
            3: begin
               z_m = r_m[1:0];
               chk("ptrz", rp[9:8], z_m);
            end
         endcase
         chk("pc", pc_out, pc_m);
      end
      for (i = 0; i < 8; i = i + 1) begin
         r_m = 8'($urandom);
         issue(4'(`NCSS_OP_LD_HBITS + i % 3), 2'h1, 1'b0, {6'h00, r_m});
         if (i % 3 == 0) chk("hbits", hb, r_m[2:0]);
         if (i % 3 == 1) chk("pair", pair, r_m);
      end
      for (i = 0; i < 6; i = i + 1) begin
         r_m = 8'($urandom);
         issue(`NCSS_OP_LD_RLD, 2'h1, 1'b0, {3'h0, i[2:0], r_m});
         chk("rld", rlds[8*i +: 8], i == 5 ? {4'h0, r_m[3:0]} : r_m);
      end
      ret_m = nxt(pc_m);
      issue(`NCSS_OP_CALL, 2'h2, 1'b0, 14'h3F7F);
      pc_m = 14'h3F7F;
      chk("sp", sp, 3'h0);
      issue(`NCSS_OP_LD_A, 2'h3, 1'b0, 14'h0005);
      a_m = 4'h5;
      chk("busy", nb[15:0], 16'h0002);
      chk("pc", pc_out, 14'h3F00);
      issue(`NCSS_OP_RET, 2'h2, 1'b0, 14'h0000);
      pc_m = ret_m;
      chk("pc", pc_out, pc_m);
      issue(`NCSS_OP_SKIP, 2'h1, 1'b0, 14'h0000);
      issue(`NCSS_OP_LD_A, 2'h1, 1'b0, 14'h000A);
      a_m = 4'hA;
      chk("acc", acc, a_m);
      chk("supp", ns[15:0], 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
         issue(`NCSS_OP_SKIP, 2'h1, 1'b1, 14'h0000);
         issue(skp_ops[15-4*i -: 4], 2'h3, 1'b0, {10'h000, ~a_m});
         chk("supp", ns[15:0], 16'h0001);
         chk("busy", nb[15:0], i == 0 ? 16'h0002 : 16'h0000);
         chk("pc", pc_out, pc_m);
         chk("acc", acc, a_m);
         chk("sp", sp, 3'h7);
      end
      // Reset again in mid-run: sp, pc and acc must be back at reset values after two reset edges
      rst_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      chk("sp", sp, 3'h7);
      chk("pc", pc_out, 14'h0000);
      chk("acc", acc, 4'h0);
      test_done;
   end
   initial begin
      #20000;
      n_fail = n_fail + 1;
      test_done;
   end
endmodule
